// File: hw/qps_consts.svh
// constants for the quad pot spi block
// assumes inclusion by bare name from the modules and the bench
`ifndef QPS_CONSTS_SVH
`define QPS_CONSTS_SVH
`define QPS_ADDR_WIPER0 5'h00
`define QPS_ADDR_WIPER3 5'h03
`define QPS_ADDR_ACCESS 5'h10
`define QPS_WIPER_RESET 8'h80
`define QPS_ACCESS_RESET 8'h40
`define QPS_ACCESS_MASK 8'h42
`define QPS_BIT_SHUTDOWN_ENABLE_N_N 6
`define QPS_BIT_OPEN_DRAIN 1
`define QPS_ECHO_CODE 3'h7
`define QPS_OFF_CTRL 8'h00
`define QPS_OFF_TXDATA 8'h04
`define QPS_OFF_STATUS 8'h08
`define QPS_OFF_RXDATA 8'h0c
`define QPS_CTRL_GO 0
`define QPS_CTRL_HOLD 1
`define QPS_SCK_HALF 4
`endif

// File: hw/qps_dev.sv
// pot device end: serial command decode and register file
// assumes spi mode 0 from the host, sck stands still while cs_n high
`timescale 1ns/10ps
`include "qps_consts.svh"
module qps_dev (
  // power-on reset, active low, asynchronous to sck
  input wire logic por_n,
  // link
  qps_link_if.dev link,
  // register outputs
  output logic [7:0] wiper_position_0,
  output logic [7:0] wiper_position_1,
  output logic [7:0] wiper_position_2,
  output logic [7:0] wiper_position_3,
  output logic shutdown_enable_n
);
  import qps_pkg::*;

  logic [15:0] shift_ff;
  logic [3:0] cnt_ff;
  logic [7:0] wiper_ff [4];
  logic [7:0] access_control_ff;
  logic [7:0] pend_instr_ff;
  logic pend_ff;
  logic [15:0] load_ff;
  logic load_req_ff;
  logic miso_ff;
  logic miso_bit;
  logic first_ff;
  logic started_ff;
  logic fell_ff;
  logic [15:0] nxt_reply;

  function automatic logic [7:0] read_reg(input logic [4:0] a);
    logic [7:0] r;
    r = 8'h00;
    if (a <= `QPS_ADDR_WIPER3) r = wiper_ff[a[1:0]];
    else if (a == `QPS_ADDR_ACCESS) r = access_control_ff & `QPS_ACCESS_MASK;
    return r;
  endfunction : read_reg

  function automatic logic is_rd(input logic [2:0] op);
    return (op == QPS_OP_RD) || (op == QPS_OP_ACC_RD);
  endfunction : is_rd

  // echo byte then data; chained replies echo the fixed code
  function automatic logic [15:0] reply(input logic [7:0] ins, input logic chained);
    logic [4:0] a;
    logic [2:0] e;
    a = (ins[7:5] == QPS_OP_ACC_RD) ? `QPS_ADDR_ACCESS : ins[4:0];
    e = chained ? `QPS_ECHO_CODE : ins[7:5];
    return {e, a, read_reg(a)};
  endfunction : reply

  // reply for a read latched in the previous frame
  always_comb begin
    nxt_reply = reply(pend_instr_ff, 1'b1);
  end

  // bit counter; first pair of a frame may be a read
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      cnt_ff <= 4'h0;
      load_req_ff <= 1'b0;
      first_ff <= 1'b1;
      started_ff <= 1'b0;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
      started_ff <= 1'b1;
      if (cnt_ff == 4'hf) first_ff <= 1'b0;
      load_req_ff <= (cnt_ff == 4'hf) && first_ff && is_rd(shift_ff[14:12]);
    end
  end

  // in-frame read reply, taken as the sixteenth bit arrives
  always_ff @(posedge link.sck) begin
    if (cnt_ff == 4'hf) load_ff <= reply(shift_ff[14:7], 1'b0);
  end

  // input shift path, msb first, sampled on rising sck
  always_ff @(posedge link.sck) begin
    if (pend_ff && !started_ff) shift_ff <= {nxt_reply[14:0], link.mosi};
    else if (load_req_ff) shift_ff <= {load_ff[14:0], link.mosi};
    else shift_ff <= {shift_ff[14:0], link.mosi};
  end

  // output changes on falling sck
  always_ff @(negedge link.sck) begin
    miso_ff <= load_req_ff ? load_ff[15] : shift_ff[15];
  end

  // first falling edge of the frame hands over from the pending msb
  always_ff @(negedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) fell_ff <= 1'b0;
    else fell_ff <= 1'b1;
  end

  // commit on cs rise; reads latch for the next two bytes or frame
  always_ff @(posedge link.cs_n or negedge por_n) begin
    if (!por_n) begin
      for (int i = 0; i < 4; i++) wiper_ff[i] <= `QPS_WIPER_RESET;
      access_control_ff <= `QPS_ACCESS_RESET;
      pend_ff <= 1'b0;
      pend_instr_ff <= 8'h00;
    end else begin
      pend_ff <= 1'b0;
      unique case (qps_op_t'(shift_ff[15:13]))
        QPS_OP_WR: begin
          if (shift_ff[12:8] <= `QPS_ADDR_WIPER3) wiper_ff[shift_ff[9:8]] <= shift_ff[7:0];
          else if (shift_ff[12:8] == `QPS_ADDR_ACCESS) access_control_ff <= shift_ff[7:0] & `QPS_ACCESS_MASK;
        end
        QPS_OP_ACC_WR: access_control_ff <= shift_ff[7:0] & `QPS_ACCESS_MASK;
        QPS_OP_RD, QPS_OP_ACC_RD: begin
          pend_ff <= 1'b1;
          pend_instr_ff <= shift_ff[15:8];
        end
        default: ;
      endcase
    end
  end

  assign miso_bit = (pend_ff && !fell_ff) ? nxt_reply[15] : miso_ff;
  assign link.miso_o = miso_bit;
  // open drain releases on one, push-pull drives; cs high releases
  assign link.miso_oe_n = link.cs_n | (access_control_ff[`QPS_BIT_OPEN_DRAIN] & miso_bit);

  assign wiper_position_0 = wiper_ff[0];
  assign wiper_position_1 = wiper_ff[1];
  assign wiper_position_2 = wiper_ff[2];
  assign wiper_position_3 = wiper_ff[3];
  assign shutdown_enable_n = access_control_ff[`QPS_BIT_SHUTDOWN_ENABLE_N_N];
endmodule : qps_dev

// File: hw/qps_host.sv
// host controller: axi4-lite registers drive spi mode 0 frames
// assumes aclk 250 MHz, miso from the link domain
`timescale 1ns/10ps
`include "qps_consts.svh"
module qps_host #(
  parameter int SCK_HALF = `QPS_SCK_HALF
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // link
  qps_link_if.host link
);
  import qps_pkg::*;
  initial if (SCK_HALF < 1 || SCK_HALF > 256) $error("SCK_HALF must be 1 to 256");

  typedef enum logic [1:0] {QPS_IDLE, QPS_LOW, QPS_HIGH} qps_st_t;
  qps_st_t st_ff;
  logic [7:0] tx_ff, rx_ff;
  logic hold_ff, busy_ff, done_ff;
  logic [2:0] bit_ff;
  logic [7:0] div_ff;
  logic sck_ff, cs_n_ff, mosi_ff;
  logic aw_ff, w_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic miso_s;
  logic go;

  qps_sync #(.W(1)) u_sync (.clk(aclk), .rst_n(aresetn), .d(link.miso), .q(miso_s));

  // write channel capture, address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
      end
      if (aw_ff && w_ff && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end
  assign s_axi_awready = !aw_ff && !s_axi_bvalid;
  assign s_axi_wready = !w_ff && !s_axi_bvalid;
  assign s_axi_bresp = 2'b00;
  assign go = aw_ff && w_ff && !s_axi_bvalid && awaddr_ff == `QPS_OFF_CTRL
    && wdata_ff[`QPS_CTRL_GO] && s_axi_wstrb[0] && !busy_ff;

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_arready <= 1'b1;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      unique case (s_axi_araddr)
        `QPS_OFF_CTRL: s_axi_rdata <= {30'h0, hold_ff, 1'b0};
        `QPS_OFF_TXDATA: s_axi_rdata <= {24'h0, tx_ff};
        `QPS_OFF_STATUS: s_axi_rdata <= {30'h0, done_ff, busy_ff};
        `QPS_OFF_RXDATA: s_axi_rdata <= {24'h0, rx_ff};
        default: s_axi_rdata <= 32'h0;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
  assign s_axi_rresp = 2'b00;

  // byte engine: mode 0, msb first, cs held while hold set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= QPS_IDLE;
      sck_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      mosi_ff <= 1'b0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      bit_ff <= 3'h0;
      div_ff <= 8'h00;
      tx_ff <= 8'h00;
      rx_ff <= 8'h00;
      hold_ff <= 1'b0;
    end else begin
      if (aw_ff && w_ff && !s_axi_bvalid && awaddr_ff == `QPS_OFF_TXDATA && !busy_ff) tx_ff <= wdata_ff[7:0];
      if (aw_ff && w_ff && !s_axi_bvalid && awaddr_ff == `QPS_OFF_CTRL && !busy_ff) begin
        hold_ff <= wdata_ff[`QPS_CTRL_HOLD];
        if (!wdata_ff[`QPS_CTRL_HOLD] && !wdata_ff[`QPS_CTRL_GO]) cs_n_ff <= 1'b1;
      end
      unique case (st_ff)
        QPS_IDLE: if (go) begin
          busy_ff <= 1'b1;
          done_ff <= 1'b0;
          cs_n_ff <= 1'b0;
          mosi_ff <= tx_ff[7];
          bit_ff <= 3'h7;
          div_ff <= 8'h00;
          st_ff <= QPS_LOW;
        end
        QPS_LOW: if (div_ff == 8'(SCK_HALF - 1)) begin
          div_ff <= 8'h00;
          sck_ff <= 1'b1;
          rx_ff <= {rx_ff[6:0], miso_s};
          st_ff <= QPS_HIGH;
        end else div_ff <= div_ff + 8'h01;
        QPS_HIGH: if (div_ff == 8'(SCK_HALF - 1)) begin
          div_ff <= 8'h00;
          sck_ff <= 1'b0;
          if (bit_ff == 3'h0) begin
            st_ff <= QPS_IDLE;
            busy_ff <= 1'b0;
            done_ff <= 1'b1;
            if (!hold_ff) cs_n_ff <= 1'b1;
          end else begin
            bit_ff <= bit_ff - 3'h1;
            mosi_ff <= tx_ff[bit_ff - 3'h1];
            st_ff <= QPS_LOW;
          end
        end else div_ff <= div_ff + 8'h01;
      endcase
    end
  end

  assign link.sck = sck_ff;
  assign link.cs_n = cs_n_ff;
  assign link.mosi = mosi_ff;
endmodule : qps_host

// File: hw/qps_link_if.sv
// spi link between host controller and pot device
// assumes an external pull-up resolves open-drain data
`timescale 1ns/10ps
interface qps_link_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic miso_o;
  logic miso_oe_n;
  wire miso = miso_oe_n ? 1'b1 : miso_o;
  modport host (output sck, output cs_n, output mosi, input miso);
  modport dev (input sck, input cs_n, input mosi, output miso_o, output miso_oe_n);
endinterface : qps_link_if

// File: hw/qps_pkg.sv
// types for the quad pot spi block
// assumes qps_consts.svh on the include path
package qps_pkg;
  typedef enum logic [2:0] {
    QPS_OP_NOP = 3'h0,
    QPS_OP_ACC_RD = 3'h1,
    QPS_OP_ACC_WR = 3'h3,
    QPS_OP_RD = 3'h4,
    QPS_OP_WR = 3'h6
  } qps_op_t;
  typedef logic [7:0] qps_byte_t;
endpackage : qps_pkg

// File: hw/qps_sync.sv
// two flop level synchroniser
// assumes a level input from another clock domain
`timescale 1ns/10ps
module qps_sync #(parameter int W = 1) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_ff <= '0;
      q <= '0;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule : qps_sync

// File: sim/qps_link_asserts.sv
// link checker for the quad pot spi host and device pair
// assumes link signals sampled on aclk, host makes sck from aclk
`timescale 1ns/10ps
module qps_link_asserts #(
  parameter int SCK_HALF = 4
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe_n
);
  logic [2:0] bits_ff;
  logic [7:0] half_ff;
  logic sck_q_ff;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // sck rises within the frame, mod 8
  always_ff @(posedge aclk) begin
    sck_q_ff <= sck;
    if (!aresetn || cs_n) bits_ff <= 3'h0;
    else if (sck && !sck_q_ff) bits_ff <= bits_ff + 3'h1;
  end
  // aclk cycles since sck last changed
  always_ff @(posedge aclk) begin
    if (!aresetn || sck != sck_q_ff) half_ff <= 8'h00;
    else half_ff <= half_ff + 8'h01;
  end
  a_idle_released: assert property (cs_n && $past(cs_n) |-> miso_oe_n)
    else $error("data line driven while deselected");
  a_idle_sck_low: assert property (cs_n |-> !sck)
    else $error("sck high while deselected");
  a_frame_starts_low: assert property ($fell(cs_n) |-> !sck && !$past(sck))
    else $error("frame opened with sck high");
  a_frame_whole_bytes: assert property ($rose(cs_n) |-> $past(bits_ff) == 3'h0)
    else $error("frame closed inside a byte");
  a_mosi_held_high: assert property (!cs_n && sck && $past(sck) |-> $stable(mosi))
    else $error("mosi moved while sck high");
  a_miso_on_fall: assert property (!cs_n && !$past(cs_n) && $changed(miso_o) |-> !sck)
    else $error("miso moved on a rising sck");
  a_sck_half_period: assert property ($fell(sck) |-> half_ff == SCK_HALF - 1)
    else $error("sck high time wrong");
  a_sck_after_select: assert property ($rose(sck) |-> !$past(cs_n))
    else $error("sck rose before select");
endmodule : qps_link_asserts

// File: sim/quad_pot_spi_register_access_tb.sv
// bench for the quad pot spi host and device pair
// assumes both ends joined by one link, aclk at 4 ns
`timescale 1ns/10ps
`include "qps_consts.svh"
module quad_pot_spi_register_access_tb;
  import qps_pkg::*;
  logic aclk = 0, aresetn = 0, por_n = 0, sd_n;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, rnd;
  logic [7:0] wp[4];
  logic [7:0] wx[4];
  logic [7:0] bad[5] = '{8'h00, 8'h40, 8'ha0, 8'he0, 8'hc4};
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  logic [31:0] exp_q[$], msk_q[$];
  int err_count = 0, samples_checked = 0;
  integer seed = 32'ha4c8777b;
  qps_link_if link();
  always #2 aclk = ~aclk;
  qps_host #(.SCK_HALF(4)) qps_host_inst(.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .link(link));
  qps_dev qps_dev_inst(.por_n(por_n), .link(link), .wiper_position_0(wp[0]), .wiper_position_1(wp[1]),
    .wiper_position_2(wp[2]), .wiper_position_3(wp[3]), .shutdown_enable_n(sd_n));
  qps_link_asserts #(.SCK_HALF(4)) qps_link_asserts_inst(.aclk(aclk), .aresetn(aresetn), .sck(link.sck),
    .cs_n(link.cs_n), .mosi(link.mosi), .miso_o(link.miso_o), .miso_oe_n(link.miso_oe_n));
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  // read results, oldest note first
  always @(negedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1 && exp_q.size() > 0) begin
      if (msk_q[0] !== 32'h0) cmp("read data", exp_q[0], rdata & msk_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_t, w_t, b_t;
    @(posedge aclk);
    awvalid <= 1;
    awaddr <= a;
    wvalid <= 1;
    wdata <= d;
    bready <= 1;
    do begin
      @(negedge aclk);
      aw_t = awvalid & awready;
      w_t = wvalid & wready;
      b_t = bvalid === 1'b1;
      @(posedge aclk);
      if (aw_t) awvalid <= 0;
      if (w_t) wvalid <= 0;
    end while (!b_t);
    bready <= 0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, output logic [31:0] d);
    logic ar_t, r_t;
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    @(posedge aclk);
    arvalid <= 1;
    araddr <= a;
    rready <= 1;
    do begin
      @(negedge aclk);
      ar_t = arvalid & arready;
      r_t = rvalid === 1'b1;
      d = rdata;
      @(posedge aclk);
      if (ar_t) arvalid <= 0;
    end while (!r_t);
    rready <= 0;
  endtask : axi_rd
  task automatic spi_byte(input logic [7:0] tx, input logic hold, input logic [7:0] e, input logic [7:0] m);
    logic [31:0] s;
    axi_wr(`QPS_OFF_TXDATA, {24'h0, tx});
    axi_wr(`QPS_OFF_CTRL, {30'h0, hold, 1'b1});
    do axi_rd(`QPS_OFF_STATUS, 0, 0, s); while (s[0] !== 1'b0);
    axi_rd(`QPS_OFF_RXDATA, {24'h0, e}, {24'h0, m}, s);
  endtask : spi_byte
  task automatic rd4(input logic [7:0] ins, input logic [7:0] echo, input logic [7:0] e);
    spi_byte(ins, 1, 0, 0);
    spi_byte(8'h00, 1, 0, 0);
    spi_byte(8'h00, 1, echo, 8'hff);
    spi_byte(8'h00, 0, e, 8'hff);
  endtask : rd4
  task automatic wr2(input logic [7:0] ins, input logic [7:0] d);
    spi_byte(ins, 1, 0, 0);
    spi_byte(d, 1, 0, 0);
    axi_wr(`QPS_OFF_CTRL, 0);
    repeat (4) @(posedge aclk);
  endtask : wr2
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  initial begin
    #200000;
    err_count++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    por_n <= 1;
    cmp("wipers", {4{`QPS_WIPER_RESET}}, {wp[0], wp[1], wp[2], wp[3]});
    for (int i = 0; i < 4; i++) rd4({QPS_OP_RD, 5'(i)}, {QPS_OP_RD, 5'(i)}, 8'h80);
    rd4({QPS_OP_ACC_RD, 5'h00}, {QPS_OP_ACC_RD, 5'h10}, 8'h40);
    $display("defaults done");
    for (int i = 0; i < 4; i++) begin
      rnd = 8'($random(seed));
      wx[i] = rnd;
      spi_byte({QPS_OP_WR, 5'(i)}, 1, 0, 0);
      spi_byte(rnd, 1, 0, 0);
      cmp("before commit", 8'h80, wp[i]);
      axi_wr(`QPS_OFF_CTRL, 0);
      repeat (4) @(posedge aclk);
      cmp("after commit", rnd, wp[i]);
      rd4({QPS_OP_RD, 5'(i)}, {QPS_OP_RD, 5'(i)}, rnd);
    end
    $display("wiper writes done");
    wr2({QPS_OP_ACC_WR, 5'h1f}, 8'h00);
    cmp("shutdown", 0, sd_n);
    rnd = 8'($random(seed));
    wr2({QPS_OP_WR, 5'h10}, rnd);
    cmp("shutdown", rnd[6], sd_n);
    rd4({QPS_OP_RD, 5'h10}, {QPS_OP_RD, 5'h10}, rnd & 8'h42);
    foreach (bad[k]) begin
      wr2(bad[k], 8'h5a);
      cmp("wipers", {wx[0], wx[1], wx[2], wx[3]}, {wp[0], wp[1], wp[2], wp[3]});
    end
    $display("access and refused codes done");
    rnd = 8'($random(seed));
    spi_byte({QPS_OP_WR, 5'h1}, 1, 0, 0);
    spi_byte(~rnd, 1, 0, 0);
    spi_byte({QPS_OP_WR, 5'h2}, 1, {QPS_OP_WR, 5'h1}, 8'hff);
    spi_byte(rnd, 0, ~rnd, 8'hff);
    wx[2] = rnd;
    repeat (4) @(posedge aclk);
    cmp("wipers", {wx[0], wx[1], wx[2], wx[3]}, {wp[0], wp[1], wp[2], wp[3]});
    $display("chain write done");
    spi_byte({QPS_OP_RD, 5'h3}, 1, 0, 0);
    spi_byte(8'h00, 0, 0, 0);
    spi_byte(8'h00, 1, {`QPS_ECHO_CODE, 5'h3}, 8'hff);
    spi_byte(8'h00, 0, wx[3], 8'hff);
    $display("chain read done");
    repeat (4) @(posedge aclk);
    stop_test();
  end
endmodule : quad_pot_spi_register_access_tb
